// *** logic/mbh_ctrl.sv ***
// Mode button and five-lamp operator interface of the scanner.
// Assumes button and core signals synchronous to ref_clk, debounced.
// Behaviour
// - Failure blinks ready and no-read lamps together
// - Other failure alone lights good-read lamp steadily
// - Motor failure lights reading-phase lamp steadily
// - Laser failure lights link-activity lamp steadily
// - Optional diagnostic message names the failure
// - Button ignored in idle while motor or laser off
// - Press shows no-read; hold steps; release enters
// - Test mode shows bar graph; none blinks
// - Single press leaves test mode
// - Discovery turns laser on, blinks its lamp
// - Up to ten codes; steady on detection
// - Several codes in line enable multi-label
// - Press ends discovery; restart then store codes
// - Tuning turns laser on, blinks; steady on detect
// - Tuning ends on decode or seven seconds
// - After tuning restart then store parameters
// - Tuning never alters enabled symbologies
// - Held at power-up restores factory, blinks thrice
// - Test mode ends itself after two minutes
// - Startup and restart blink all lamps one second
`timescale 1ns/100ps
`default_nettype none
module mbh_ctrl
    import mbh_pkg::*;
#(
    parameter longint unsigned TEST_TIMEOUT = TEST_TIMEOUT_CYC,
    parameter int unsigned TUNE_TIMEOUT = TUNE_TIMEOUT_CYC,
    parameter int unsigned STARTUP_TIME = STARTUP_CYC,
    parameter int unsigned HOLD_STEP = HOLD_STEP_CYC,
    parameter int unsigned FACTORY_TIME = FACTORY_CYC,
    parameter int unsigned BLINK_HALF = BLINK_CYC
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Asynchronous reset, high
    input wire logic clk_en, // Freezes all state while low
    input wire logic button, // Mode button, high while pressed
    input wire logic diag_en, // Diagnostic message option
    input wire mbh_core_t core, // Status from decoder core
    output var mbh_cmd_t cmd, // Commands to decoder core
    output logic [4:0] lamp // Lamps: ready,good,phase,link,noread
);
    typedef struct packed {
        mbh_state_t st;
        mbh_func_t fn;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] blink_cnt;
        logic blink;
        logic btn_q;
        logic first;
        logic [3:0] codes;
        logic [1:0] fblinks;
        logic found;
        logic fail_q;
        mbh_cmd_t cmd;
        logic [4:0] lamp;
    } mbh_regs_t;

    mbh_regs_t s_reg;
    mbh_regs_t s_next;

    logic press;
    logic release_ev;
    logic any_fail;
    logic healthy;
    logic cnt_done_step;

    assign press = button && !s_reg.btn_q;
    assign release_ev = !button && s_reg.btn_q;
    assign any_fail = core.motor_fail || core.laser_fail || core.other_fail;
    assign healthy = core.motor_on && core.laser_on;
    assign cnt_done_step = s_reg.cnt >= CNT_W'(HOLD_STEP - 1);

    always_comb begin
        s_next = s_reg;
        s_next.btn_q = button;
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        s_next.cmd.restart = 1'b0;
        s_next.cmd.store_codes = 1'b0;
        s_next.cmd.store_tuning = 1'b0;
        s_next.cmd.diag_valid = 1'b0;
        // Free-running blink phase shared by all lamps
        if (s_reg.blink_cnt >= CNT_W'(BLINK_HALF - 1)) begin
            s_next.blink_cnt = '0;
            s_next.blink = !s_reg.blink;
        end else begin
            s_next.blink_cnt = s_reg.blink_cnt + CNT_W'(1);
        end
        // One message per new failure when the option is on
        s_next.fail_q = any_fail;
        if (diag_en && any_fail && !s_reg.fail_q) begin
            s_next.cmd.diag_valid = 1'b1;
            s_next.cmd.diag_code = core.motor_fail ? DIAG_MOTOR :
                core.laser_fail ? DIAG_LASER : DIAG_OTHER;
        end
        case (s_reg.st)
            ST_STARTUP: begin
                s_next.lamp = {5{s_reg.blink}};
                if (s_reg.first && s_reg.cnt == '0 && button) begin
                    s_next.st = ST_FACTORY;
                    s_next.cmd.factory_restore = 1'b1;
                    s_next.cnt = '0;
                end else if (s_reg.cnt >= CNT_W'(STARTUP_TIME - 1)) begin
                    s_next.st = ST_IDLE;
                    s_next.first = 1'b0;
                    s_next.btn_q = 1'b1;
                end
            end
            ST_FACTORY: begin
                s_next.lamp = '0;
                if (s_reg.cnt >= CNT_W'(FACTORY_TIME - 1)) begin
                    s_next.cmd.factory_restore = 1'b0;
                    s_next.st = ST_FBLINK;
                    s_next.cnt = '0;
                    s_next.fblinks = '0;
                end
            end
            ST_FBLINK: begin
                s_next.lamp = (s_reg.cnt < CNT_W'(BLINK_HALF)) ? '1 : '0;
                if (s_reg.cnt >= CNT_W'(2 * BLINK_HALF - 1)) begin
                    s_next.cnt = '0;
                    s_next.fblinks = s_reg.fblinks + 2'h1;
                    if (s_reg.fblinks == 2'(FACTORY_BLINKS - 1)) begin
                        s_next.st = ST_STARTUP;
                        s_next.first = 1'b0;
                    end
                end
            end
            ST_IDLE: begin
                s_next.cnt = '0;
                if (any_fail) begin
                    s_next.lamp[LAMP_READY] = s_reg.blink;
                    s_next.lamp[LAMP_NOREAD] = s_reg.blink;
                    s_next.lamp[LAMP_GOOD] = core.other_fail &&
                        !core.motor_fail && !core.laser_fail;
                    s_next.lamp[LAMP_PHASE] = core.motor_fail;
                    s_next.lamp[LAMP_LINK] = core.laser_fail;
                end else begin
                    s_next.lamp = '0;
                    s_next.lamp[LAMP_READY] = 1'b1;
                    s_next.lamp[LAMP_GOOD] = core.good_read;
                    s_next.lamp[LAMP_NOREAD] = core.no_read;
                end
                if (press && healthy) begin
                    s_next.st = ST_HOLD;
                    s_next.fn = FN_TEST;
                    s_next.lamp = '0;
                    s_next.lamp[LAMP_NOREAD] = 1'b1;
                end
            end
            ST_HOLD: begin
                if (!healthy) begin
                    s_next.st = ST_IDLE;
                end else if (release_ev) begin
                    s_next.cnt = '0;
                    s_next.found = 1'b0;
                    s_next.codes = '0;
                    case (s_reg.fn)
                        FN_TEST: s_next.st = ST_TEST;
                        FN_DISC: begin
                            s_next.st = ST_DISC;
                            s_next.cmd.laser_force_on = 1'b1;
                        end
                        default: begin
                            s_next.st = ST_TUNE;
                            s_next.cmd.laser_force_on = 1'b1;
                            s_next.cmd.tune_active = 1'b1;
                        end
                    endcase
                end else if (cnt_done_step) begin
                    s_next.cnt = '0;
                    s_next.fn = (s_reg.fn == FN_TUNE) ? FN_TEST :
                        mbh_func_t'(s_reg.fn + 2'h1);
                end
                if (healthy && !release_ev) begin
                    s_next.lamp = '0;
                    case (s_next.fn)
                        FN_TEST: s_next.lamp[LAMP_NOREAD] = 1'b1;
                        FN_DISC: s_next.lamp[LAMP_PHASE] = 1'b1;
                        default: s_next.lamp[LAMP_LINK] = 1'b1;
                    endcase
                end
            end
            ST_TEST: begin
                for (int i = 0; i < 5; i++) begin
                    s_next.lamp[i] = 32'(core.rate_level) > i;
                end
                if (core.rate_level == 3'h0) begin
                    s_next.lamp = '0;
                    s_next.lamp[LAMP_NOREAD] = s_reg.blink;
                end
                if (press || 64'(s_reg.cnt) >= TEST_TIMEOUT - 1) begin
                    s_next.st = ST_IDLE;
                    s_next.btn_q = 1'b1;
                end
            end
            ST_DISC: begin
                s_next.lamp = '0;
                s_next.lamp[LAMP_PHASE] = s_reg.found ? 1'b1 :
                    s_reg.blink;
                if (core.code_found &&
                        s_reg.codes < 4'(DISCOVER_MAX)) begin
                    s_next.codes = s_reg.codes + 4'h1;
                    s_next.found = 1'b1;
                    s_next.cnt = '0;
                    if (core.multi_in_line) begin
                        s_next.cmd.multi_label_en = 1'b1;
                    end
                end else if (s_reg.found && cnt_done_step) begin
                    s_next.found = 1'b0;
                end
                if (press) begin
                    s_next.st = ST_RESTART;
                    s_next.fn = FN_DISC;
                    s_next.cnt = '0;
                    s_next.cmd.laser_force_on = 1'b0;
                    s_next.cmd.restart = 1'b1;
                end
            end
            ST_TUNE: begin
                s_next.lamp = '0;
                s_next.lamp[LAMP_LINK] = s_reg.found ? 1'b1 :
                    s_reg.blink;
                if (core.code_found) begin
                    s_next.found = 1'b1;
                end
                if (core.good_read ||
                        s_reg.cnt >= CNT_W'(TUNE_TIMEOUT - 1)) begin
                    s_next.st = ST_RESTART;
                    s_next.fn = FN_TUNE;
                    s_next.cnt = '0;
                    s_next.cmd.laser_force_on = 1'b0;
                    s_next.cmd.tune_active = 1'b0;
                    s_next.cmd.restart = 1'b1;
                end
            end
            ST_RESTART: begin
                s_next.lamp = {5{s_reg.blink}};
                if (s_reg.cnt >= CNT_W'(STARTUP_TIME - 1)) begin
                    s_next.st = ST_STORE;
                end
            end
            ST_STORE: begin
                s_next.cmd.store_codes = (s_reg.fn == FN_DISC);
                s_next.cmd.store_tuning = (s_reg.fn == FN_TUNE);
                s_next.st = ST_IDLE;
                s_next.btn_q = 1'b1;
            end
            default: s_next.st = ST_IDLE;
        endcase
        // A failure takes over the lamps in the operating modes too
        if (any_fail && s_next.st == s_reg.st &&
                (s_reg.st == ST_TEST || s_reg.st == ST_DISC ||
                s_reg.st == ST_TUNE)) begin
            s_next.lamp[LAMP_READY] = s_reg.blink;
            s_next.lamp[LAMP_NOREAD] = s_reg.blink;
            s_next.lamp[LAMP_GOOD] = core.other_fail &&
                !core.motor_fail && !core.laser_fail;
            s_next.lamp[LAMP_PHASE] = core.motor_fail;
            s_next.lamp[LAMP_LINK] = core.laser_fail;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.st <= ST_STARTUP;
            s_reg.first <= 1'b1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign cmd = s_reg.cmd;
    assign lamp = s_reg.lamp;
endmodule
`default_nettype wire

// *** logic/mbh_pkg.sv ***
// Package for the mode button and lamp controller.
// Assumes a 125 MHz system clock.
package mbh_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned STARTUP_MS = 1000;
    localparam int unsigned STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
    localparam int unsigned HOLD_STEP_MS = 1000;
    localparam int unsigned HOLD_STEP_CYC = CLK_HZ / 1000 * HOLD_STEP_MS;
    localparam int unsigned TUNE_TIMEOUT_S = 7;
    localparam int unsigned TUNE_TIMEOUT_CYC = CLK_HZ * TUNE_TIMEOUT_S;
    localparam int unsigned TEST_TIMEOUT_S = 120;
    localparam longint unsigned TEST_TIMEOUT_CYC =
        64'(CLK_HZ) * TEST_TIMEOUT_S;
    localparam int unsigned FACTORY_MS = 5500;
    localparam int unsigned FACTORY_CYC = CLK_HZ / 1000 * FACTORY_MS;
    localparam int unsigned FACTORY_BLINKS = 3;
    localparam int unsigned DISCOVER_MAX = 10;
    localparam int unsigned CNT_W = 34;

    // Lamp vector bit positions
    localparam int unsigned LAMP_READY = 0;
    localparam int unsigned LAMP_GOOD = 1;
    localparam int unsigned LAMP_PHASE = 2;
    localparam int unsigned LAMP_LINK = 3;
    localparam int unsigned LAMP_NOREAD = 4;

    // Diagnostic message codes
    localparam logic [1:0] DIAG_OTHER = 2'h0;
    localparam logic [1:0] DIAG_MOTOR = 2'h1;
    localparam logic [1:0] DIAG_LASER = 2'h2;

    typedef enum logic [3:0] {
        ST_STARTUP = 4'h0,
        ST_IDLE = 4'h1,
        ST_HOLD = 4'h3,
        ST_TEST = 4'h2,
        ST_DISC = 4'h6,
        ST_TUNE = 4'h7,
        ST_RESTART = 4'h5,
        ST_STORE = 4'h4,
        ST_FACTORY = 4'hC,
        ST_FBLINK = 4'hD
    } mbh_state_t;

    typedef enum logic [1:0] {
        FN_TEST = 2'h0,
        FN_DISC = 2'h1,
        FN_TUNE = 2'h2
    } mbh_func_t;

    // Health and decode events from the decoder core
    typedef struct packed {
        logic motor_fail;
        logic laser_fail;
        logic other_fail;
        logic motor_on;
        logic laser_on;
        logic good_read;
        logic no_read;
        logic code_found;
        logic multi_in_line;
        logic [2:0] rate_level;
    } mbh_core_t;

    // Commands towards the decoder core, all registered
    typedef struct packed {
        logic laser_force_on;
        logic restart;
        logic store_codes;
        logic store_tuning;
        logic tune_active;
        logic multi_label_en;
        logic factory_restore;
        logic diag_valid;
        logic [1:0] diag_code;
    } mbh_cmd_t;
endpackage

// *** dv/mbh_ctrl_assertions.sv ***
// Assertion checker for the mode button and lamp controller.
// Bound to mbh_ctrl; sees its ports only, assumes clk_en held high.
`timescale 1ns/100ps
`default_nettype none
module mbh_ctrl_assertions
    import mbh_pkg::*;
#(
    parameter int unsigned STARTUP_TIME = STARTUP_CYC
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Clock enable
    input wire logic button, // Mode button
    input wire logic diag_en, // Diagnostic option
    input wire mbh_core_t core, // Core status
    input wire mbh_cmd_t cmd, // Core commands
    input wire logic [4:0] lamp // Lamps
);
    localparam int STORE_HI = STARTUP_TIME + 16;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    restart_pulse_a: assert property (cmd.restart |=> !cmd.restart)
        else $error("restart longer than one cycle");
    store_pulse_a: assert property (
        (cmd.store_codes || cmd.store_tuning) |=>
        !(cmd.store_codes || cmd.store_tuning))
        else $error("store longer than one cycle");
    restart_store_a: assert property (
        cmd.restart |-> ##[1:STORE_HI] (cmd.store_codes || cmd.store_tuning))
        else $error("no store after restart");
    diag_gate_a: assert property (
        cmd.diag_valid |-> $past(diag_en) && ($past(core.motor_fail) ||
        $past(core.laser_fail) || $past(core.other_fail)))
        else $error("diagnostic without cause");
    diag_code_a: assert property (
        cmd.diag_valid |-> cmd.diag_code == ($past(core.motor_fail) ?
        DIAG_MOTOR : $past(core.laser_fail) ? DIAG_LASER : DIAG_OTHER))
        else $error("wrong diagnostic code");
    tune_laser_a: assert property (
        cmd.tune_active |-> cmd.laser_force_on)
        else $error("tuning without laser");
    tune_keep_a: assert property (cmd.tune_active |-> !cmd.store_codes)
        else $error("tuning stored code types");
    multi_sticky_a: assert property (!$fell(cmd.multi_label_en))
        else $error("multi-label mode dropped");
    button_off_a: assert property (
        (!core.motor_on || !core.laser_on) && $rose(button) |=> lamp != 5'h10)
        else $error("press taken while motor or laser off");
    restart_blink_a: assert property (
        cmd.restart |-> ##[1:12] lamp == 5'h1f)
        else $error("no lamp blink after restart");
endmodule
bind mbh_ctrl mbh_ctrl_assertions #(.STARTUP_TIME(STARTUP_TIME))
    i_mbh_ctrl_assertions (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .button(button), .diag_en(diag_en), .core(core), .cmd(cmd), .lamp(lamp));
`default_nettype wire

// *** dv/mbh_operator.sv ***
// Operator model: presses the button, holds it until the wanted lamp
// pattern shows or a cycle cap runs out, then lets go.
`timescale 1ns/100ps
`default_nettype none
module mbh_operator (
    input wire logic ref_clk, // Clock
    input wire logic go, // Start a press
    input wire logic power_hold, // Held through power-up
    input wire logic [4:0] want, // Pattern to release on
    input wire logic [7:0] cap, // Longest hold in cycles
    input wire logic [4:0] lamp, // Lamps seen
    output logic button // Mode button
);
    logic pressed = 1'b0;
    logic [7:0] held = 8'h00;
    logic g;
    assign button = pressed | power_hold;
    always @(posedge ref_clk) begin
        g = go;
        #1;
        if (!pressed && g) begin
            pressed = 1'b1;
            held = 8'h00;
        end else if (pressed && (lamp === want || held == cap)) begin
            pressed = 1'b0;
        end else begin
            held = held + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** dv/test_mbh_ctrl.sv ***
// Self-checking bench for the mode button and lamp controller.
// Shortened counts; the operator model works the button.
`timescale 1ns/100ps
`default_nettype none
module test_mbh_ctrl;
    import mbh_pkg::*;
    localparam int TT = 200, TU = 100, SU = 40, HS = 20, FT = 60;
    logic ref_clk = 1'b0, rst = 1'b1, diag_en = 1'b0, go = 1'b0;
    logic power_hold = 1'b1, button;
    logic [4:0] lamp, want = 5'h10;
    logic [7:0] cap = 8'h03;
    mbh_core_t core = '{motor_on: 1'b1, laser_on: 1'b1, default: '0};
    mbh_cmd_t cmd;
    int errors = 0, cmp_count = 0;
    always #4 ref_clk = ~ref_clk;
    mbh_ctrl #(.TEST_TIMEOUT(TT), .TUNE_TIMEOUT(TU), .STARTUP_TIME(SU),
        .HOLD_STEP(HS), .FACTORY_TIME(FT), .BLINK_HALF(4)) i_mbh_ctrl (
        .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .button(button),
        .diag_en(diag_en), .core(core), .cmd(cmd), .lamp(lamp));
    mbh_operator i_mbh_operator (.ref_clk(ref_clk), .go(go),
        .power_hold(power_hold), .want(want), .cap(cap), .lamp(lamp),
        .button(button));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_lamp(input logic [4:0] got, input logic [4:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: lamp %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? cmd.restart : sel == 1 ? cmd.store_codes :
            cmd.store_tuning;
    endfunction
    task automatic wait_for(input int sel, input int lim, output int n);
        for (n = 0; n < lim && pick(sel) !== 1'b1; n++) step(1);
    endtask
    task automatic press(input logic [4:0] w, input logic [7:0] c);
        int i;
        want = w;
        cap = c;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (i = 0; i < 300 && !button; i++) step(1);
        for (i = 0; i < 300 && button; i++) step(1);
    endtask
    task automatic t_factory;
        int n;
        int rises;
        logic [4:0] prev;
        for (n = 0; n < 10 && cmd.factory_restore !== 1'b1; n++) step(1);
        power_hold = 1'b0;
        for (n = 0; n < 500 && cmd.factory_restore === 1'b1; n++) step(1);
        chk_bit(1'(n == FT), 1'b1);
        prev = lamp;
        rises = 0;
        // Each blink lasts two half periods of four cycles
        repeat (FACTORY_BLINKS * 8) begin
            step(1);
            rises += int'(lamp === 5'h1f && prev !== 5'h1f);
            prev = lamp;
        end
        chk_bit(1'(rises == FACTORY_BLINKS), 1'b1);
        step(SU + 20);
    endtask
    task automatic t_refuse;
        core.motor_on = 1'b0;
        press(5'h10, 8'h04);
        chk_bit(cmd.laser_force_on, 1'b0);
        chk_lamp(lamp, 5'h01);
        core.motor_on = 1'b1;
        step(4);
    endtask
    task automatic t_test;
        logic on, off, bad;
        core.rate_level = 3'd3;
        press(5'h10, 8'hc8);
        step(3);
        chk_lamp(lamp, 5'h07);
        core.rate_level = 3'd0;
        {on, off, bad} = 3'b000;
        repeat (12) begin
            step(1);
            on |= lamp === 5'h10;
            off |= lamp === 5'h00;
            bad |= lamp !== 5'h10 && lamp !== 5'h00;
        end
        chk_bit(on & off & !bad, 1'b1);
        core.rate_level = 3'd5;
        step(3);
        chk_lamp(lamp, 5'h1f);
        core.rate_level = 3'd3;
        press(5'h1f, 8'h03);
        step(4);
        chk_bit(1'(lamp === 5'h07), 1'b0);
        press(5'h10, 8'hc8);
        step(3);
        chk_lamp(lamp, 5'h07);
        step(TT + 10);
        chk_bit(1'(lamp === 5'h07), 1'b0);
    endtask
    task automatic t_disc;
        int n;
        logic off;
        press(5'h04, 8'hc8);
        step(2);
        chk_bit(cmd.laser_force_on, 1'b1);
        for (int k = 0; k < DISCOVER_MAX; k++) begin
            core.code_found = 1'b1;
            core.multi_in_line = 1'(k == 0);
            step(1);
            core.code_found = 1'b0;
            core.multi_in_line = 1'b0;
            step(3);
            chk_lamp(lamp, 5'h04);
            step(HS);
        end
        chk_bit(cmd.multi_label_en, 1'b1);
        core.code_found = 1'b1;
        step(1);
        core.code_found = 1'b0;
        off = 1'b0;
        repeat (8) begin
            step(1);
            off |= lamp === 5'h00;
        end
        chk_bit(off, 1'b1);
        // Short press; the restart pulse comes while the button is held
        cap = 8'h03;
        go = 1'b1;
        step(1);
        go = 1'b0;
        wait_for(0, 10, n);
        chk_bit(cmd.restart, 1'b1);
        wait_for(1, SU + 20, n);
        chk_bit(cmd.store_codes, 1'b1);
        step(4);
    endtask
    task automatic t_tune(input logic hit);
        int n;
        press(5'h08, 8'hc8);
        step(2);
        chk_bit(cmd.tune_active & cmd.laser_force_on, 1'b1);
        if (hit) begin
            core.code_found = 1'b1;
            step(1);
            core.code_found = 1'b0;
            step(3);
            chk_lamp(lamp, 5'h08);
            core.good_read = 1'b1;
            step(1);
            core.good_read = 1'b0;
        end
        wait_for(0, TU + 20, n);
        chk_bit(1'(hit ? n < 6 : n >= TU - 12 && n <= TU), 1'b1);
        wait_for(2, SU + 20, n);
        chk_bit(cmd.store_tuning, 1'b1);
        chk_bit(cmd.store_codes, 1'b0);
        step(4);
    endtask
    task automatic t_fail;
        logic [4:0] fm [3] = '{5'h02, 5'h04, 5'h08};
        logic [1:0] dc [3] = '{DIAG_OTHER, DIAG_MOTOR, DIAG_LASER};
        logic got, sync, on, off;
        logic [1:0] code;
        diag_en = 1'b1;
        for (int k = 0; k < 3; k++) begin
            core.other_fail = 1'(k == 0);
            core.motor_fail = 1'(k == 1);
            core.laser_fail = 1'(k == 2);
            {got, sync, on, off} = 4'b0100;
            code = 2'h3;
            repeat (4) begin
                step(1);
                if (cmd.diag_valid === 1'b1) begin
                    {got, code} = {1'b1, cmd.diag_code};
                end
            end
            chk_bit(got & (code === dc[k]), 1'b1);
            repeat (12) begin
                step(1);
                sync &= lamp[0] === lamp[4];
                on |= lamp[0] === 1'b1;
                off |= lamp[0] === 1'b0;
            end
            chk_bit(sync & on & off, 1'b1);
            chk_lamp(lamp & 5'h0e, fm[k]);
            {core.other_fail, core.motor_fail, core.laser_fail} = 3'b000;
            step(6);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end
    initial begin
        step(8);
        rst = 1'b0;
        t_factory();
        t_refuse();
        t_test();
        t_disc();
        t_tune(1'b0);
        t_tune(1'b1);
        t_fail();
        summarize();
    end
endmodule
`default_nettype wire
